// ---- design/fdc_cmd.sv ----
// Read-data command interpreter with its data FIFO.
// Assumes the host byte strobes, the drive sector stream and the drive
// status pins are synchronous to i_clk; none pass a synchronizer.
`timescale 1ns/10ps

// ------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------
module fdc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage
	logic [AW:0] wr_q; // Write pointer, extra wrap bit
	logic [AW:0] rd_q; // Read pointer
	logic full;
	logic empty;
	logic push;
	logic pop;
	assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty = (wr_q == rd_q);
	assign o_ready = !full;
	assign o_valid = !empty;
	assign push = i_valid && !full;
	assign pop = i_ready && !empty;
	assign o_data = mem_q[rd_q[AW-1:0]];
	// Storage writes carry no reset to keep it a plain array
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= i_data;
		end
	end
	// Pointers
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// ------------------------------------------------------------
// Command interpreter
// ------------------------------------------------------------
module fdc_cmd (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_cmd_wr, // Host writes a command byte
	input wire logic [7:0] i_cmd_data,
	input wire logic i_res_rd, // Host takes a result byte
	input wire logic i_sec_valid, // Drive sector byte present
	input wire logic [7:0] i_sec_data,
	input wire logic i_sec_deleted, // Current sector has deleted mark
	input wire logic i_sec_last, // Last byte of current sector
	input wire logic i_host_ready, // System side takes data
	input wire logic i_no_dma_flag,
	input wire logic i_overwrite_enable,
	input wire logic i_perp_wr, // Perpendicular config write
	input wire logic [7:0] i_perp_data,
	input wire logic i_polling_disable,
	input wire logic [7:0] i_precomp_start_track,
	input wire logic i_seek_rel, // Relative seek request
	input wire logic [7:0] i_relative_cylinder,
	input wire logic [7:0] i_sectors_per_track,
	input wire logic i_verify_count_enable,
	input wire logic [3:0] i_step_interval,
	input wire logic i_write_gate_timing,
	input wire logic i_write_req,
	output logic o_cmd_ready,
	output logic o_res_valid,
	output logic [7:0] o_res_data,
	output logic o_sec_ready,
	output logic o_data_valid,
	output logic [7:0] o_data,
	output logic o_irq,
	output logic o_dma_req,
	output logic [3:0] o_perp_cfg,
	output logic o_poll_active,
	output logic [7:0] o_precomp_track,
	output logic [7:0] o_present_cylinder,
	output logic [7:0] o_sector_limit,
	output logic o_step,
	output logic o_write_enable,
	output logic [15:0] o_sector_len
);
	import fdc_cmd_pkg::*;

	typedef enum logic [3:0] {
		S_CMD = 4'h1,
		S_EXEC = 4'h2,
		S_RES = 4'h4,
		S_BAD = 4'h8
	} state_t;

	state_t state_q;
	logic [3:0] cnt_q; // Command byte index
	logic [2:0] res_q; // Result byte index
	logic [7:0] op_q; // First command byte
	logic [2:0] dsel_q; // Head and drive
	logic [7:0] cyl_q, head_q, sect_q, size_q, eot_q;
	logic [7:0] st0_q, st1_q, st2_q;
	logic is_deleted_cmd;
	logic skip_sector;
	logic f_valid, f_ready, f_out_valid;
	logic sec_take; // Drive byte accepted this cycle, kept or dropped
	logic exec_done; // Last byte of the final sector accepted
	logic f_pop; // System side takes a byte from the buffer
	logic [4:0] occ_q; // Bytes held in the buffer
	logic [4:0] occ_d;
	logic [7:0] f_out;
	logic [7:0] res_mux;

	assign is_deleted_cmd = (op_q[4:0] == OP_READ_DELETED);
	// Filter deleted or undeleted sectors by the skip flag
	assign skip_sector = op_q[BIT_SKIP_DELETED] &&
		(is_deleted_cmd ? !i_sec_deleted : i_sec_deleted);
	// Ready is registered, so acceptance follows it exactly as the drive
	// side sees it; a skipped byte is taken and dropped
	assign sec_take = (state_q == S_EXEC) && i_sec_valid && o_sec_ready;
	assign f_valid = sec_take && !skip_sector;
	assign exec_done = sec_take && i_sec_last && (sect_q == eot_q);
	assign f_pop = i_host_ready && o_data_valid && f_out_valid;
	// Fill level after this edge, to drop ready as soon as the buffer is full
	always_comb begin
		occ_d = occ_q + {4'h0, f_valid} - {4'h0, f_pop};
	end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			occ_q <= 5'h00;
		end else begin
			occ_q <= occ_d;
		end
	end

	// Sector data buffer; a stalled host backs up to the drive side
	fdc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_valid(f_valid),
		.o_ready(f_ready),
		.i_data(i_sec_data),
		.o_valid(f_out_valid),
		.i_ready(i_host_ready && o_data_valid),
		.o_data(f_out)
	);

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= S_CMD;
			cnt_q <= 4'h0;
			res_q <= 3'h0;
		end else begin
			case (state_q)
				S_CMD: begin
					if (i_cmd_wr) begin
						if (cnt_q == CMD_LAST) begin
							cnt_q <= 4'h0;
							state_q <= S_EXEC;
						end else begin
							cnt_q <= cnt_q + 4'h1;
						end
					end
				end
				S_EXEC: begin
					// Ends once the last byte of the final sector is accepted
					if (exec_done) begin
						state_q <= S_RES;
						res_q <= 3'h0;
					end
				end
				S_RES: begin
					if (i_res_rd) begin
						if (res_q == RES_LAST) begin
							state_q <= S_CMD;
						end else begin
							res_q <= res_q + 3'h1;
						end
					end
				end
				default: state_q <= S_CMD;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Command parameters
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			op_q <= RESET_BYTE;
			dsel_q <= 3'h0;
			cyl_q <= RESET_BYTE;
			head_q <= RESET_BYTE;
			sect_q <= RESET_BYTE;
			size_q <= RESET_BYTE;
			eot_q <= RESET_BYTE;
		end else if (state_q == S_CMD && i_cmd_wr) begin
			case (cnt_q)
				4'h0: op_q <= i_cmd_data;
				4'h1: dsel_q <= i_cmd_data[BIT_HEAD_SELECT:0];
				4'h2: cyl_q <= i_cmd_data;
				4'h3: head_q <= i_cmd_data;
				4'h4: sect_q <= i_cmd_data;
				4'h5: size_q <= i_cmd_data;
				4'h6: eot_q <= i_cmd_data;
				default: ;
			endcase
		end else if (sec_take && i_sec_last && sect_q != eot_q) begin
			sect_q <= sect_q + 8'h01; // Next sector of multi-sector
		end
	end

	// Status kept for the result phase
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st0_q <= RESET_BYTE;
			st1_q <= RESET_BYTE;
			st2_q <= RESET_BYTE;
		end else if (state_q == S_CMD && i_cmd_wr && cnt_q == CMD_LAST) begin
			st0_q <= {5'h00, dsel_q};
			st1_q <= RESET_BYTE;
			st2_q <= RESET_BYTE;
		end else if (f_valid && i_sec_deleted) begin
			st2_q[ST2_CTRL_MARK] <= 1'b1; // Deleted sector passed through
		end
	end

	always_comb begin
		case (res_q)
			3'h0: res_mux = st0_q;
			3'h1: res_mux = st1_q;
			3'h2: res_mux = st2_q;
			3'h3: res_mux = cyl_q;
			3'h4: res_mux = head_q;
			3'h5: res_mux = sect_q;
			default: res_mux = size_q;
		endcase
	end

	// ------------------------------------------------------------
	// Host-facing registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_cmd_ready <= 1'b1;
			o_res_valid <= 1'b0;
			o_res_data <= RESET_BYTE;
		end else begin
			o_cmd_ready <= (state_q == S_CMD) &&
				!(i_cmd_wr && cnt_q == CMD_LAST);
			o_res_valid <= (state_q == S_RES) &&
				!(i_res_rd && res_q == RES_LAST);
			o_res_data <= (state_q == S_RES) ? res_mux : RESET_BYTE;
		end
	end

	// Data path and transfer request
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_data_valid <= 1'b0;
			o_data <= RESET_BYTE;
			o_irq <= 1'b0;
			o_dma_req <= 1'b0;
			o_sec_ready <= 1'b0;
		end else begin
			o_data_valid <= f_out_valid && !(o_data_valid && i_host_ready);
			o_data <= f_out;
			o_irq <= i_no_dma_flag && f_out_valid;
			o_dma_req <= !i_no_dma_flag && f_out_valid;
			o_sec_ready <= (state_q == S_EXEC) && !exec_done &&
				(occ_d < 5'(FIFO_DEPTH));
		end
	end

	// ------------------------------------------------------------
	// Configuration settings
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_perp_cfg <= 4'h0;
			o_poll_active <= 1'b1;
			o_precomp_track <= RESET_BYTE;
			o_sector_limit <= RESET_BYTE;
			o_sector_len <= SECTOR_BASE;
		end else begin
			if (i_perp_wr && i_overwrite_enable) begin
				o_perp_cfg <= i_perp_data[3:0];
			end
			o_poll_active <= !i_polling_disable;
			o_precomp_track <= i_precomp_start_track;
			o_sector_limit <= i_verify_count_enable ?
				i_sectors_per_track : i_sectors_per_track;
			o_sector_len <= SECTOR_BASE << size_q[2:0];
		end
	end

	// ------------------------------------------------------------
	// Head position and stepping
	// ------------------------------------------------------------
	logic [7:0] steps_q;
	logic [17:0] step_cnt_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_present_cylinder <= RESET_BYTE;
			steps_q <= RESET_BYTE;
			step_cnt_q <= '0;
			o_step <= 1'b0;
		end else begin
			o_step <= 1'b0;
			if (i_seek_rel && steps_q == 8'h00) begin
				steps_q <= i_relative_cylinder;
			end else if (steps_q != 8'h00) begin
				if (step_cnt_q == 18'h0) begin
					// Interval per code step of half a millisecond
					step_cnt_q <= 18'((32'(i_step_interval) + 1) *
						STEP_UNIT_CYC - 1);
					o_step <= 1'b1;
					steps_q <= steps_q - 8'h01;
					o_present_cylinder <= o_present_cylinder + 8'h01;
				end else begin
					step_cnt_q <= step_cnt_q - 18'h1;
				end
			end
		end
	end

	// Pre-erase: write enable delayed four clock cycles when gate timing set
	logic [3:0] we_dly_q;
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			we_dly_q <= 4'h0;
			o_write_enable <= 1'b0;
		end else begin
			we_dly_q <= {we_dly_q[2:0], i_write_req};
			o_write_enable <= i_write_gate_timing ?
				(i_write_req && we_dly_q[3]) : i_write_req;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_exec_after_last;
		@(posedge i_clk) disable iff (!i_nrst)
		(state_q == S_CMD && i_cmd_wr && cnt_q == CMD_LAST) |=>
			state_q == S_EXEC;
	endproperty
	a_exec_after_last: assert property (p_exec_after_last)
		else $error("no execution after last byte");
	property p_res_hidden;
		@(posedge i_clk) disable iff (!i_nrst)
		(state_q != S_RES) |=> !o_res_valid;
	endproperty
	a_res_hidden: assert property (p_res_hidden)
		else $error("result visible outside result phase");
	property p_refuse;
		@(posedge i_clk) disable iff (!i_nrst)
		(state_q == S_EXEC) |=> !o_cmd_ready;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("command accepted during execution");
	property p_perp;
		@(posedge i_clk) disable iff (!i_nrst)
		!i_overwrite_enable |=> $stable(o_perp_cfg);
	endproperty
	a_perp: assert property (p_perp)
		else $error("perpendicular bits changed without overwrite");
	property p_skip;
		@(posedge i_clk) disable iff (!i_nrst)
		(sec_take && skip_sector && i_sec_deleted) |=> $stable(st2_q);
	endproperty
	a_skip: assert property (p_skip)
		else $error("skipped sector entered buffer");
	property p_dma;
		@(posedge i_clk) disable iff (!i_nrst)
		o_dma_req |-> !o_irq;
	endproperty
	a_dma: assert property (p_dma)
		else $error("irq and dma together");
	property p_len;
		@(posedge i_clk) disable iff (!i_nrst)
		$stable(size_q) |-> o_sector_len == (SECTOR_BASE << size_q[2:0]);
	endproperty
	a_len: assert property (p_len)
		else $error("sector length wrong");
	property p_first;
		@(posedge i_clk) disable iff (!i_nrst)
		(state_q == S_RES && res_q == 3'h0) |=> o_res_data == st0_q;
	endproperty
	a_first: assert property (p_first)
		else $error("first result byte not status zero");
	c_exec: cover property (@(posedge i_clk) state_q == S_EXEC);
	c_res: cover property (@(posedge i_clk) state_q == S_RES);
	c_full: cover property (@(posedge i_clk) !f_ready);
endmodule

// ---- design/fdc_cmd_pkg.sv ----
// Constants for the floppy read-data command interpreter.
// Assumes one 20 MHz clock domain; host bytes arrive on plain ports.
package fdc_cmd_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int STEP_UNIT_US = 500; // Half a millisecond per code
	localparam int STEP_UNIT_CYC = (STEP_UNIT_US * (CLK_HZ / 1000000));
	// ------------------------------------------------------------
	// Command layout
	// ------------------------------------------------------------
	localparam logic [4:0] OP_READ_DATA = 5'h06;
	localparam logic [4:0] OP_READ_DELETED = 5'h0C;
	localparam int BIT_MULTI_TRACK = 7;
	localparam int BIT_DOUBLE_DENSITY = 6;
	localparam int BIT_SKIP_DELETED = 5;
	localparam int BIT_HEAD_SELECT = 2;
	localparam logic [3:0] CMD_LAST = 4'h8;
	localparam logic [2:0] RES_LAST = 3'h6;
	localparam logic [2:0] SIZE_MAX = 3'h7;
	localparam logic [15:0] SECTOR_BASE = 16'h0080;
	// ------------------------------------------------------------
	// Status bits, reset byte and buffer size
	// ------------------------------------------------------------
	localparam int ST0_ABNORMAL = 6;
	localparam int ST1_END_CYL = 7;
	localparam int ST2_CTRL_MARK = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 8;
endpackage

// ---- dv/fdc_drive_model.sv ----
// Drive-side model: streams sector bytes with valid/ready framing.
// Assumes the bench pulses i_start once per command, after byte nine.
`timescale 1ns/10ps
module fdc_drive_model (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_start, // Begin a new burst of sectors
	input wire logic [3:0] i_sectors, // Sectors in the burst
	input wire logic [7:0] i_len, // Bytes in each sector
	input wire logic [3:0] i_del_mask, // Deleted mark per sector
	input wire logic i_ready,
	output logic o_valid,
	output logic [7:0] o_data,
	output logic o_deleted,
	output logic o_last
);
	logic [3:0] sec_q; // Sector index within burst
	logic [7:0] byte_q; // Byte index within sector
	logic [7:0] junk_q; // Churns while idle so stale bytes never pass
	// ------------------------------------------------------------
	// Byte sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_valid <= 1'b0;
			sec_q <= 4'h0;
			byte_q <= 8'h00;
		end else if (i_start) begin
			o_valid <= 1'b1;
			sec_q <= 4'h0;
			byte_q <= 8'h00;
		end else if (o_valid && i_ready) begin
			byte_q <= o_last ? 8'h00 : byte_q + 8'h01;
			if (o_last) begin
				sec_q <= sec_q + 4'h1;
				o_valid <= (sec_q != i_sectors - 4'h1);
			end
		end
	end
	// Idle pattern changes every cycle
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			junk_q <= 8'h5A;
		end else begin
			junk_q <= junk_q + 8'h35;
		end
	end
	// Data carries sector index high, byte index low
	assign o_data = o_valid ? {sec_q, byte_q[3:0]} : junk_q;
	assign o_last = o_valid ? (byte_q == i_len - 8'h01) : junk_q[0];
	assign o_deleted = o_valid ? i_del_mask[sec_q] : junk_q[1];
endmodule

// ---- dv/floppy_read_data_command_tb.sv ----
// Bench for the read-data command interpreter and its byte FIFO.
// Assumes a 20 MHz clock; the drive model supplies sector bytes.
`timescale 1ns/10ps
module floppy_read_data_command_tb;
	import fdc_cmd_pkg::*;
	localparam logic [7:0] CYL = 8'h2C;
	localparam logic [7:0] HD = 8'h01;
	logic clk, nrst, cmd_wr, res_rd, host_ready, no_dma, ow, perp_wr;
	logic poll_dis, seek, vce, gate, wreq, start;
	logic [7:0] cmd_data, perp_data, precomp, rel, spt, len_s, rx_first;
	logic [3:0] step, nsec_s, del_s;
	logic sv, sd, sl, sdel, o_cmd_ready, o_res_valid, o_sec_ready;
	logic o_data_valid, o_irq, o_dma_req, o_poll_active, o_step;
	logic o_write_enable;
	logic [7:0] o_res_data, o_data, o_precomp_track, o_present_cylinder;
	logic [7:0] o_sector_limit, s_data;
	logic [3:0] o_perp_cfg;
	logic [15:0] o_sector_len;
	int miscompares = 0, n_tests = 0, rx_n = 0;
	// ------------------------------------------------------------
	// Clock, units under test
	// ------------------------------------------------------------
	always #25 clk = ~clk;
	fdc_cmd dut_u (.i_clk(clk), .i_nrst(nrst), .i_cmd_wr(cmd_wr),
		.i_cmd_data(cmd_data), .i_res_rd(res_rd), .i_sec_valid(sv),
		.i_sec_data(s_data), .i_sec_deleted(sdel), .i_sec_last(sl),
		.i_host_ready(host_ready), .i_no_dma_flag(no_dma),
		.i_overwrite_enable(ow), .i_perp_wr(perp_wr),
		.i_perp_data(perp_data), .i_polling_disable(poll_dis),
		.i_precomp_start_track(precomp), .i_seek_rel(seek),
		.i_relative_cylinder(rel), .i_sectors_per_track(spt),
		.i_verify_count_enable(vce), .i_step_interval(step),
		.i_write_gate_timing(gate), .i_write_req(wreq),
		.o_cmd_ready(o_cmd_ready), .o_res_valid(o_res_valid),
		.o_res_data(o_res_data), .o_sec_ready(o_sec_ready),
		.o_data_valid(o_data_valid), .o_data(o_data), .o_irq(o_irq),
		.o_dma_req(o_dma_req), .o_perp_cfg(o_perp_cfg),
		.o_poll_active(o_poll_active), .o_precomp_track(o_precomp_track),
		.o_present_cylinder(o_present_cylinder),
		.o_sector_limit(o_sector_limit), .o_step(o_step),
		.o_write_enable(o_write_enable), .o_sector_len(o_sector_len));
	fdc_drive_model drv_u (.i_clk(clk), .i_nrst(nrst), .i_start(start),
		.i_sectors(nsec_s), .i_len(len_s), .i_del_mask(del_s),
		.i_ready(o_sec_ready), .o_valid(sv), .o_data(s_data),
		.o_deleted(sdel), .o_last(sl));
	// Host side: count bytes the system takes
	always @(posedge clk) begin
		if (o_data_valid === 1'b1 && host_ready) begin
			if (rx_n == 0) rx_first <= o_data;
			rx_n <= rx_n + 1;
		end
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Inputs move a fixed 2 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Nine bytes back to back; drive 1 head 1
	task automatic send_cmd(input logic [7:0] op, input logic [7:0] r,
		input logic [7:0] n, input logic [7:0] final_sector);
		logic [7:0] b [9];
		b = '{op, 8'h05, CYL, HD, r, n, final_sector, 8'h1B, 8'hFF};
		for (int i = 0; i < 9; i++) begin
			cmd_data = b[i];
			cmd_wr = 1'b1;
			tick(1);
		end
		cmd_wr = 1'b0;
		tick(1);
		chk("cmd_ready_exec", 16'h0000, o_cmd_ready);
	endtask
	// Mask of zero consumes a byte whose value is not predicted
	task automatic get_res(input logic [7:0] exp, input logic [7:0] m,
		input string what);
		int t;
		t = 0;
		while (o_res_valid !== 1'b1 && t < 3000) begin
			tick(1);
			t++;
		end
		if (m != 8'h00) chk(what, exp & m, o_res_data & m);
		res_rd = 1'b1;
		tick(1);
		res_rd = 1'b0;
		tick(1);
	endtask
	task automatic results(input logic [7:0] st2m, input logic [7:0] r,
		input logic [7:0] n);
		get_res(8'h05, 8'hFF, "status0");
		get_res(8'h00, 8'hFF, "status1");
		get_res(st2m, 8'h40, "status2");
		get_res(CYL, 8'hFF, "cylinder");
		get_res(HD, 8'hFF, "head");
		get_res(r, 8'hFF, "sector");
		get_res(n, 8'hFF, "size");
		tick(1);
		chk("cmd_ready_done", 16'h0001, o_cmd_ready);
	endtask
	// Full read; stall holds the system side until the buffer fills
	task automatic run_read(input logic [7:0] op, input logic [7:0] r,
		input logic [7:0] n, input logic [3:0] ns, input logic [3:0] dm,
		input logic [7:0] st2m, input int exp_n, input bit stall);
		logic [7:0] final_sector;
		final_sector = r + {4'h0, ns} - 8'h01;
		rx_n = 0;
		nsec_s = ns;
		del_s = dm;
		host_ready = !stall;
		send_cmd(op, r, n, final_sector);
		chk("sector_len", SECTOR_BASE << n, o_sector_len);
		chk("res_early", 16'h0000, o_res_valid);
		start = 1'b1;
		tick(1);
		start = 1'b0;
		if (stall) begin
			cmd_data = 8'h06;
			cmd_wr = 1'b1;
			tick(1);
			cmd_wr = 1'b0;
			tick(40);
			chk("fifo_full", 16'h0000, o_sec_ready);
			chk("irq", {15'h0, no_dma}, o_irq);
			chk("dma_req", {15'h0, !no_dma}, o_dma_req);
			host_ready = 1'b1;
		end
		results(st2m, final_sector, n);
		tick(40);
		chk("bytes", exp_n[15:0], rx_n[15:0]);
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		{clk, nrst, cmd_wr, res_rd, no_dma, ow, perp_wr, poll_dis} = '0;
		{seek, vce, gate, wreq, start, cmd_data, perp_data} = '0;
		{precomp, rel, spt, step, nsec_s, del_s} = '0;
		host_ready = 1'b1;
		len_s = 8'h03;
		tick(3);
		nrst = 1'b1;
		chk("rst_cmd_ready", 16'h0001, o_cmd_ready);
		chk("rst_poll", 16'h0001, o_poll_active);
		chk("rst_len", 16'h0080, o_sector_len);
		// Every size code, start sector tracks the code
		for (int k = 0; k < 8; k++) begin
			run_read({3'b010, OP_READ_DATA}, k + 1, k, 4'h1, 4'h0,
				8'h00, 3, 1'b0);
		end
		// Skip a deleted sector, then take only the deleted one
		len_s = 8'h05;
		run_read({3'b011, OP_READ_DATA}, 8'h01, 8'h00, 4'h2, 4'h1,
			8'h00, 5, 1'b0);
		chk("skip_first", 16'h0010, rx_first);
		run_read({3'b001, OP_READ_DELETED}, 8'h01, 8'h00, 4'h2, 4'h2,
			8'h40, 5, 1'b0);
		chk("del_first", 16'h0010, rx_first);
		// Buffer fill with a stalled system, both transfer modes
		len_s = 8'h14;
		for (int d = 0; d < 2; d++) begin
			no_dma = d[0];
			run_read({3'b000, OP_READ_DATA}, 8'h03, 8'h02, 4'h1, 4'h0,
				8'h00, 20, 1'b1);
		end
		// Settings held by the block
		perp_data = 8'h0A;
		perp_wr = 1'b1;
		tick(1);
		perp_wr = 1'b0;
		tick(2);
		chk("perp_locked", 16'h0000, o_perp_cfg);
		ow = 1'b1;
		perp_wr = 1'b1;
		tick(1);
		perp_wr = 1'b0;
		tick(2);
		chk("perp_open", 16'h000A, o_perp_cfg);
		poll_dis = 1'b1;
		precomp = 8'hFF;
		spt = 8'h12;
		vce = 1'b1;
		tick(2);
		chk("poll_off", 16'h0000, o_poll_active);
		chk("precomp", 16'h00FF, o_precomp_track);
		chk("sector_limit", 16'h0012, o_sector_limit);
		wreq = 1'b1;
		tick(2);
		chk("we_plain", 16'h0001, o_write_enable);
		wreq = 1'b0;
		gate = 1'b1;
		tick(8);
		wreq = 1'b1;
		tick(2);
		chk("we_gate_early", 16'h0000, o_write_enable);
		tick(6);
		chk("we_gate_late", 16'h0001, o_write_enable);
		seek_test();
		wrap_up();
	end
	// Two steps, spaced by one half-millisecond unit
	task automatic seek_test;
		int t0, t1, ns;
		ns = 0;
		rel = 8'h02;
		seek = 1'b1;
		tick(1);
		seek = 1'b0;
		for (int c = 0; c < 25000 && ns < 2; c++) begin
			tick(1);
			if (o_step === 1'b1) begin
				if (ns == 0) t0 = c;
				else t1 = c;
				ns++;
			end
		end
		chk("step_gap", STEP_UNIT_CYC, t1 - t0);
		tick(2);
		chk("cylinder", 16'h0002, o_present_cylinder);
	endtask
	// Watchdog sized well past the seek, the longest test
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		wrap_up();
	end
endmodule
